//--- hdl/ddmap_pkg.sv
package ddmap_pkg;

  // Array geometry and word layout
  localparam int ROW_AW        = 8;
  localparam int ROWS          = 256;
  localparam int REG_W         = 40;
  localparam int WORD_W        = 32;
  localparam int SHORT_W       = 16;
  localparam int LONG_W        = 64;
  localparam int LOW_ZERO_W    = 8;
  localparam int QUARTERS      = 4;
  localparam int WB_DEPTH      = 2;
  localparam int BUSES         = 2;
  localparam int BUS_DM        = 0;
  localparam int BUS_PM        = 1;
  localparam int SLOTS_PER_BUS = 4;
  localparam int SLOTS         = 8;

  // Slot positions inside one bus group
  localparam int SL_P_EXPL = 0;
  localparam int SL_P_NBR  = 1;
  localparam int SL_S_EXPL = 2;
  localparam int SL_S_NBR  = 3;

  localparam logic       PE_PRIMARY   = 1'b0;
  localparam logic       PE_SECONDARY = 1'b1;
  localparam logic       DM_PRIORITY  = 1'b1;
  localparam logic [3:0] NBR_FLIP     = 4'h1;
  localparam logic [3:0] QMASK_ALL    = 4'hf;
  localparam logic [3:0] QMASK_LO     = 4'h3;
  localparam logic [3:0] QMASK_HI     = 4'hc;
  localparam logic [3:0] QMASK_ONE    = 4'h1;
  localparam logic [31:0] ADDR_STEP   = 32'h1;

  typedef enum logic [1:0] {W_SHORT, W_NORMAL, W_EXT, W_LONG} ddmap_width_t;

  // One bus of a transfer as issued by the core
  typedef struct packed {
    logic         en;
    ddmap_width_t width;
    logic         pe_sel;
    logic [3:0]   idx;
    logic [31:0]  addr;
    logic [39:0]  wexpl;
    logic [39:0]  wnbr;
  } ddmap_bus_req_t;

  typedef struct packed {
    logic           valid;
    logic           write;
    logic           dual_lane;
    logic           bcast;
    ddmap_bus_req_t dm;
    ddmap_bus_req_t pm;
  } ddmap_req_t;

  typedef struct packed {
    logic        valid;
    logic        pe;
    logic [3:0]  idx;
    logic [39:0] data;
  } ddmap_rf_wr_t;

  typedef struct packed {
    logic [7:0]  row;
    logic [3:0]  qmask;
    logic [63:0] data;
  } ddmap_wb_ent_t;

endpackage

//--- hdl/ddmap_wbuf.sv
`timescale 1ns/1ps
module ddmap_wbuf (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    mem_read,
  input  wire logic                    push_v [ddmap_pkg::WB_DEPTH],
  input  wire ddmap_pkg::ddmap_wb_ent_t push_e [ddmap_pkg::WB_DEPTH],
  output logic                         pend_v [ddmap_pkg::WB_DEPTH],
  output ddmap_pkg::ddmap_wb_ent_t     pend_e [ddmap_pkg::WB_DEPTH],
  output logic                         commit_v [ddmap_pkg::WB_DEPTH]
);

  ddmap_pkg::ddmap_wb_ent_t ent_q [ddmap_pkg::WB_DEPTH];
  logic                     val_q [ddmap_pkg::WB_DEPTH];

  ////////////////////////////////////////////////////////////////////////
  // Drain only in cycles without a read; a write drains and refills
  for (genvar i = 0; i < ddmap_pkg::WB_DEPTH; i++)
  begin : g_ent
    assign commit_v[i] = val_q[i] && !mem_read;
    assign pend_v[i]   = val_q[i];
    assign pend_e[i]   = ent_q[i];

    // Entry register, empty after reset
    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
      begin
        val_q[i] <= 1'b0;
        ent_q[i] <= '0;
      end
      else if (!mem_read)
      begin
        val_q[i] <= push_v[i];
        ent_q[i] <= push_e[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_read_holds: assert property (mem_read && val_q[0] |=> val_q[0] && $stable(ent_q[0]))
    else $error("write buffer drained during a read");
  a_write_commits: assert property (push_v[0] && val_q[0] |-> commit_v[0] ##1 ent_q[0] == $past(push_e[0]))
    else $error("write cycle did not commit and accept");
  a_write_buffered: assert property (push_v[1] && !mem_read |=> val_q[1] && ent_q[1] == $past(push_e[1]))
    else $error("write went around the buffer");
  a_empty_after_reset: assert property ($past(reset) |-> !val_q[0] && !val_q[1])
    else $error("write buffer not empty after reset");

endmodule // ddmap_wbuf

//--- hdl/ddmap_path.sv
`timescale 1ns/1ps
module ddmap_path (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire ddmap_pkg::ddmap_req_t req,
  output ddmap_pkg::ddmap_rf_wr_t   rf_wr_q [ddmap_pkg::SLOTS],
  output logic                      refused_q,
  output logic                      dropped_q
);

  logic [63:0]              mem_q [ddmap_pkg::ROWS];
  ddmap_pkg::ddmap_bus_req_t bus [ddmap_pkg::BUSES];
  ddmap_pkg::ddmap_rf_wr_t   rf_d [ddmap_pkg::SLOTS];
  ddmap_pkg::ddmap_wb_ent_t  push_e [ddmap_pkg::WB_DEPTH];
  ddmap_pkg::ddmap_wb_ent_t  pend_e [ddmap_pkg::WB_DEPTH];
  logic                      push_v [ddmap_pkg::WB_DEPTH];
  logic                      pend_v [ddmap_pkg::WB_DEPTH];
  logic                      commit_v [ddmap_pkg::WB_DEPTH];
  logic                      is_sn [ddmap_pkg::BUSES];
  logic                      is_long [ddmap_pkg::BUSES];
  logic                      drop [ddmap_pkg::BUSES];
  logic [63:0]               data_e [ddmap_pkg::BUSES];
  wire                       dual_data;
  wire                       illegal;
  wire                       accept;
  wire                       load;
  wire                       mem_read;
  wire                       conflict;
  wire                       single_ld;

  ////////////////////////////////////////////////////////////////////////
  // Row of the array that holds an address of a given width
  function automatic logic [ddmap_pkg::ROW_AW-1:0] row_of(ddmap_pkg::ddmap_width_t w, logic [31:0] a);
    case (w)
      ddmap_pkg::W_SHORT:  return a[ddmap_pkg::ROW_AW+1:2];
      ddmap_pkg::W_NORMAL: return a[ddmap_pkg::ROW_AW:1];
      default:             return a[ddmap_pkg::ROW_AW-1:0];
    endcase
  endfunction

  // Lay one buffered entry over the array row when it matches
  function automatic logic [63:0] overlay(logic [ddmap_pkg::ROW_AW-1:0] r, logic [63:0] raw,
                                          ddmap_pkg::ddmap_wb_ent_t e, logic v);
    logic [63:0] d;
    d = raw;
    for (int q = 0; q < ddmap_pkg::QUARTERS; q++)
      if (v && e.row == r && e.qmask[q])
        d[q*ddmap_pkg::SHORT_W +: ddmap_pkg::SHORT_W] = e.data[q*ddmap_pkg::SHORT_W +: ddmap_pkg::SHORT_W];
    return d;
  endfunction

  // Register image of a loaded explicit or implicit word; low bits stay zero except for an extended word, which fills all 40
  function automatic logic [39:0] lane_value(ddmap_pkg::ddmap_width_t w, logic [1:0] a, logic [63:0] row);
    logic [39:0] v;
    v = '0;
    case (w)
      ddmap_pkg::W_SHORT:  v[ddmap_pkg::LOW_ZERO_W +: ddmap_pkg::SHORT_W] = row[a*ddmap_pkg::SHORT_W +: ddmap_pkg::SHORT_W];
      ddmap_pkg::W_NORMAL: v[ddmap_pkg::LOW_ZERO_W +: ddmap_pkg::WORD_W] = row[a[0]*ddmap_pkg::WORD_W +: ddmap_pkg::WORD_W];
      ddmap_pkg::W_EXT:    v = row[ddmap_pkg::LONG_W-1 -: ddmap_pkg::REG_W];
      default:             v[ddmap_pkg::LOW_ZERO_W +: ddmap_pkg::WORD_W] = row[ddmap_pkg::WORD_W-1:0];
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Transfer classification
  assign bus[ddmap_pkg::BUS_DM] = req.dm;
  assign bus[ddmap_pkg::BUS_PM] = req.pm;
  assign dual_data = req.dm.en && req.pm.en;
  assign illegal   = req.valid && req.dual_lane && dual_data && (is_sn[0] != is_sn[1]);
  assign accept    = req.valid && !illegal;
  assign load      = accept && !req.write;
  assign mem_read  = load && (req.dm.en || req.pm.en);
  assign single_ld = load && !req.dual_lane && !req.bcast;

  // Neighbour clash inside one element; the lower-priority access is dropped
  assign conflict = single_ld && dual_data && (req.dm.pe_sel == req.pm.pe_sel)
                    && ((is_long[1] && req.dm.idx == (req.pm.idx ^ ddmap_pkg::NBR_FLIP))
                    ||  (is_long[0] && req.pm.idx == (req.dm.idx ^ ddmap_pkg::NBR_FLIP)));
  assign drop[ddmap_pkg::BUS_DM] = conflict && !ddmap_pkg::DM_PRIORITY;
  assign drop[ddmap_pkg::BUS_PM] = conflict && ddmap_pkg::DM_PRIORITY;

  ////////////////////////////////////////////////////////////////////////
  // Per-bus fetch, routing and store packing
  for (genvar b = 0; b < ddmap_pkg::BUSES; b++)
  begin : g_bus
    ddmap_pkg::ddmap_bus_req_t br;
    logic [ddmap_pkg::ROW_AW-1:0] row_e;
    logic [ddmap_pkg::ROW_AW-1:0] row_i;
    logic [31:0]  iaddr;
    logic [63:0]  d_i;
    logic [39:0]  expl_v;
    logic [39:0]  impl_v;
    logic [39:0]  nbr_v;
    logic         hit_e;
    logic         hazard;
    logic         ok;
    logic         dual_sn;
    logic         bc_exc;
    logic         both;
    logic         fixed;
    logic         pe_t;
    logic         on_p;
    logic         on_s;
    logic         impl_p;

    assign br         = bus[b];
    assign is_sn[b]   = (br.width == ddmap_pkg::W_SHORT) || (br.width == ddmap_pkg::W_NORMAL);
    assign is_long[b] = (br.width == ddmap_pkg::W_LONG);

    // Explicit word, seen through the write buffer
    assign row_e     = row_of(br.width, br.addr);
    assign data_e[b] = overlay(row_e, overlay(row_e, mem_q[row_e], pend_e[0], pend_v[0]), pend_e[1], pend_v[1]);
    assign hit_e     = (pend_v[0] && pend_e[0].row == row_e) || (pend_v[1] && pend_e[1].row == row_e);

    // Implicit word of a dual-lane short/normal read
    assign hazard = hit_e && (br.width == ddmap_pkg::W_NORMAL) && br.addr[0];
    assign iaddr  = hazard ? br.addr - ddmap_pkg::ADDR_STEP : br.addr + ddmap_pkg::ADDR_STEP;
    assign row_i  = row_of(br.width, iaddr);
    assign d_i    = overlay(row_i, overlay(row_i, mem_q[row_i], pend_e[0], pend_v[0]), pend_e[1], pend_v[1]);

    assign expl_v = lane_value(br.width, br.addr[1:0], data_e[b]);
    assign impl_v = lane_value(br.width, iaddr[1:0], d_i);
    assign nbr_v  = {data_e[b][ddmap_pkg::LONG_W-1 -: ddmap_pkg::WORD_W], {ddmap_pkg::LOW_ZERO_W{1'b0}}};

    // Routing of the loaded values onto the two elements
    assign ok      = load && br.en && !drop[b];
    assign dual_sn = req.dual_lane && !req.bcast && is_sn[b];
    assign bc_exc  = req.bcast && dual_data && !is_sn[b];
    assign fixed   = (req.dual_lane && !req.bcast && !is_sn[b]) || bc_exc;
    assign both    = (req.bcast && !bc_exc) || dual_sn;
    assign pe_t    = fixed ? ((b == ddmap_pkg::BUS_PM) ? ddmap_pkg::PE_SECONDARY : ddmap_pkg::PE_PRIMARY)
                           : br.pe_sel;
    assign on_p    = ok && (both || pe_t == ddmap_pkg::PE_PRIMARY);
    assign on_s    = ok && (both || pe_t == ddmap_pkg::PE_SECONDARY);
    assign impl_p  = dual_sn && br.pe_sel != ddmap_pkg::PE_PRIMARY;

    assign rf_d[b*ddmap_pkg::SLOTS_PER_BUS+ddmap_pkg::SL_P_EXPL] =
      '{on_p, ddmap_pkg::PE_PRIMARY, br.idx, impl_p ? impl_v : expl_v};
    assign rf_d[b*ddmap_pkg::SLOTS_PER_BUS+ddmap_pkg::SL_S_EXPL] =
      '{on_s, ddmap_pkg::PE_SECONDARY, br.idx, (dual_sn && !impl_p) ? impl_v : expl_v};
    // Neighbour register of a long word, never a second memory location
    assign rf_d[b*ddmap_pkg::SLOTS_PER_BUS+ddmap_pkg::SL_P_NBR] =
      '{on_p && is_long[b], ddmap_pkg::PE_PRIMARY, br.idx ^ ddmap_pkg::NBR_FLIP, nbr_v};
    assign rf_d[b*ddmap_pkg::SLOTS_PER_BUS+ddmap_pkg::SL_S_NBR] =
      '{on_s && is_long[b], ddmap_pkg::PE_SECONDARY, br.idx ^ ddmap_pkg::NBR_FLIP, nbr_v};

    // Store packing into one buffer entry per bus
    assign push_v[b] = accept && req.write && br.en;
    always_comb
    begin
      push_e[b].row = row_e;
      case (br.width)
        ddmap_pkg::W_SHORT:
        begin
          push_e[b].qmask = ddmap_pkg::QMASK_ONE << br.addr[1:0];
          push_e[b].data  = {ddmap_pkg::QUARTERS{br.wexpl[ddmap_pkg::LOW_ZERO_W +: ddmap_pkg::SHORT_W]}};
        end
        ddmap_pkg::W_NORMAL:
        begin
          push_e[b].qmask = br.addr[0] ? ddmap_pkg::QMASK_HI : ddmap_pkg::QMASK_LO;
          push_e[b].data  = {2{br.wexpl[ddmap_pkg::LOW_ZERO_W +: ddmap_pkg::WORD_W]}};
        end
        ddmap_pkg::W_EXT:
        begin
          push_e[b].qmask = ddmap_pkg::QMASK_ALL;
          push_e[b].data  = {br.wexpl, {(ddmap_pkg::LONG_W-ddmap_pkg::REG_W){1'b0}}};
        end
        default:
        begin
          push_e[b].qmask = ddmap_pkg::QMASK_ALL;
          push_e[b].data  = {br.wnbr[ddmap_pkg::LOW_ZERO_W +: ddmap_pkg::WORD_W],
                             br.wexpl[ddmap_pkg::LOW_ZERO_W +: ddmap_pkg::WORD_W]};
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write buffer in front of the array
  ddmap_wbuf u_wbuf (
    .clk      (clk),
    .reset    (reset),
    .mem_read (mem_read),
    .push_v   (push_v),
    .push_e   (push_e),
    .pend_v   (pend_v),
    .pend_e   (pend_e),
    .commit_v (commit_v)
  );

  // Array update from committed entries; the later entry wins a shared quarter
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < ddmap_pkg::WB_DEPTH; i++)
      for (int q = 0; q < ddmap_pkg::QUARTERS; q++)
        if (commit_v[i] && pend_e[i].qmask[q])
          mem_q[pend_e[i].row][q*ddmap_pkg::SHORT_W +: ddmap_pkg::SHORT_W] <=
            pend_e[i].data[q*ddmap_pkg::SHORT_W +: ddmap_pkg::SHORT_W];
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered register-file writes and status pulses
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      for (int s = 0; s < ddmap_pkg::SLOTS; s++)
        rf_wr_q[s] <= '0;
      refused_q <= 1'b0;
      dropped_q <= 1'b0;
    end
    else
    begin
      for (int s = 0; s < ddmap_pkg::SLOTS; s++)
        rf_wr_q[s] <= rf_d[s];
      refused_q <= illegal;
      dropped_q <= conflict;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_low_bits_zero: assert property (rf_wr_q[0].valid && $past(req.dm.width) == ddmap_pkg::W_NORMAL
                                    |-> rf_wr_q[0].data[7:0] == 8'h00)
    else $error("loaded register low byte not zero");
  a_mix_refused: assert property (illegal |=> refused_q && !rf_wr_q[0].valid && !rf_wr_q[4].valid)
    else $error("illegal dual-lane width pair was carried out");
  a_single_mix_ok: assert property (req.valid && !req.dual_lane |=> !refused_q)
    else $error("single-lane width pair refused");
  a_dual_route: assert property (load && req.dual_lane && !req.bcast && is_long[0] && req.dm.en
                                 |=> rf_wr_q[0].valid && rf_wr_q[1].valid && !rf_wr_q[2].valid && !rf_wr_q[3].valid)
    else $error("dual-lane long word on wrong element");
  a_neighbour_pair: assert property (single_ld && is_long[0] && req.dm.en && req.dm.pe_sel == ddmap_pkg::PE_PRIMARY
                                     |=> rf_wr_q[1].valid && rf_wr_q[1].idx == (rf_wr_q[0].idx ^ 4'h1))
    else $error("neighbour register not written");
  a_long_lane: assert property (single_ld && is_long[0] && req.dm.en && req.dm.pe_sel == 1'b0
                                |=> rf_wr_q[1].data == {$past(data_e[0][63:32]), 8'h00}
                                 && rf_wr_q[0].data == {$past(data_e[0][31:0]), 8'h00})
    else $error("long word not spread over the full bus");
  a_conflict_drop: assert property (conflict |=> dropped_q && !rf_wr_q[4].valid && !rf_wr_q[6].valid)
    else $error("lower-priority access not dropped");
  a_bcast_both: assert property (load && req.bcast && !req.pm.en && req.dm.en && is_sn[0]
                                 |=> rf_wr_q[0].valid && rf_wr_q[2].valid && rf_wr_q[0].data == rf_wr_q[2].data)
    else $error("broadcast load not delivered to both elements");

  c_dual_long: cover property (load && req.dual_lane && dual_data && is_long[0] && is_long[1]);
  c_conflict: cover property (conflict);
  c_fwd_hazard: cover property (load && req.dual_lane && g_bus[0].hazard);
  c_write_then_read: cover property (push_v[0] ##1 mem_read);

endmodule // ddmap_path

//--- verification/ddmap_core_model.sv
`timescale 1ns/1ps
// Core-side issuer: register files and address generators ahead of the path
module ddmap_core_model (
  input  wire logic             clk,
  output ddmap_pkg::ddmap_req_t req
);
  ////////////////////////////////////////////////////////////////////////////
  // Puts one request up for the next rising edge. Every address is a pointer
  // value from an address generator, and explicit targets stay off neighbour
  // registers and illegal pairs unless the bench asks for exactly that.
  task automatic issue(input ddmap_pkg::ddmap_req_t r);
    @(negedge clk);
    req = r;
  endtask

  // Released bus: every field except valid flips each cycle so stale values never linger; valid is cleared
  task automatic idle();
    ddmap_pkg::ddmap_req_t n;
    @(negedge clk);
    n       = ~req;
    n.valid = 1'b0;
    req     = n;
  endtask

  initial req = '0;
endmodule // ddmap_core_model

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam ddmap_pkg::ddmap_width_t WN = ddmap_pkg::W_NORMAL;
  localparam ddmap_pkg::ddmap_width_t WE = ddmap_pkg::W_EXT;
  localparam ddmap_pkg::ddmap_width_t WL = ddmap_pkg::W_LONG;
  localparam ddmap_pkg::ddmap_bus_req_t OFF = '0;
  logic                    clk;
  logic                    reset;
  ddmap_pkg::ddmap_req_t   req;
  ddmap_pkg::ddmap_rf_wr_t rf_wr_q [ddmap_pkg::SLOTS];
  logic                    refused_q;
  logic                    dropped_q;
  int                      fails;
  int                      num_checks;

  ddmap_path ddmap_path_inst (.clk(clk), .reset(reset), .req(req), .rf_wr_q(rf_wr_q),
                              .refused_q(refused_q), .dropped_q(dropped_q));
  ddmap_core_model ddmap_core_model_inst (.clk(clk), .req(req));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and helpers
  initial clk = 1'b0;
  always #2 clk = ~clk;

  function automatic ddmap_pkg::ddmap_bus_req_t bus(input ddmap_pkg::ddmap_width_t w, input logic pe,
    input logic [3:0] idx, input logic [31:0] a, input logic [39:0] wx, input logic [39:0] wn);
    bus = '{1'b1, w, pe, idx, a, wx, wn};
  endfunction

  function automatic ddmap_pkg::ddmap_req_t op(input logic wr, input logic dl, input logic bc,
    input ddmap_pkg::ddmap_bus_req_t d, input ddmap_pkg::ddmap_bus_req_t p);
    op = '{1'b1, wr, dl, bc, d, p};
  endfunction

  // Expected register write of a 32-bit word, low 8 register bits zero
  function automatic logic [47:0] ex(input logic pe, input logic [3:0] idx, input logic [31:0] w);
    ex = {2'h0, 1'b1, pe, idx, w, 8'h00};
  endfunction

  // Finds the write of one bus aimed at a given element and register
  function automatic logic [47:0] pick(input int b, input logic pe, input logic [3:0] idx);
    pick = '0;
    for (int k = 0; k < ddmap_pkg::SLOTS_PER_BUS; k++)
      if (rf_wr_q[b*4+k].valid === 1'b1 && rf_wr_q[b*4+k].pe === pe && rf_wr_q[b*4+k].idx === idx)
        pick = 48'(rf_wr_q[b*4+k]);
  endfunction

  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic issue(input ddmap_pkg::ddmap_req_t r);
    ddmap_core_model_inst.issue(r);
  endtask

  // Ends the request and lands on the edge where its answer stands
  task automatic idle();
    ddmap_core_model_inst.idle();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // A write still buffered when reset hits never reaches the array
  task automatic t_reset();
    issue(op(1, 0, 0, bus(WL, 0, 0, 32'h20, 40'h11111111aa, 40'h22222222bb), OFF));
    idle();
    idle();
    issue(op(1, 0, 0, bus(WL, 0, 0, 32'h20, 40'h3333333300, 40'h4444444400), OFF));
    @(negedge clk);
    reset = 1'b1;
    idle();
    check("slot0 in reset", 48'(rf_wr_q[0]), 48'h0);
    check("refused in reset", 48'(refused_q), 48'h0);
    @(negedge clk);
    reset = 1'b0;
    issue(op(0, 0, 0, bus(WL, 0, 8, 32'h20, '0, '0), OFF));
    idle();
    check("after reset lo", 48'(rf_wr_q[0]), ex(0, 8, 32'h11111111));
    check("after reset hi", 48'(rf_wr_q[1]), ex(0, 9, 32'h22222222));
    $display("done reset_buffer");
  endtask

  // Back-to-back long stores then an immediate dual-data long load
  task automatic t_long();
    issue(op(1, 0, 0, bus(WL, 0, 0, 32'h30, 40'h0123456700, 40'h89abcdef00), OFF));
    issue(op(1, 0, 0, OFF, bus(WL, 0, 0, 32'h31, 40'h0badf00d11, 40'hfeedface22)));
    issue(op(0, 0, 0, bus(WL, 1, 2, 32'h30, '0, '0), bus(WL, 1, 12, 32'h31, '0, '0)));
    idle();
    check("dm expl", 48'(rf_wr_q[2]), ex(1, 2, 32'h01234567));
    check("dm nbr", 48'(rf_wr_q[3]), ex(1, 3, 32'h89abcdef));
    check("pm expl", 48'(rf_wr_q[6]), ex(1, 12, 32'h0badf00d));
    check("pm nbr", 48'(rf_wr_q[7]), ex(1, 13, 32'hfeedface));
    check("no drop", 48'(dropped_q), 48'h0);
    $display("done long_pair");
  endtask

  // Program bus names the data bus neighbour: only the data bus access runs
  task automatic t_conflict();
    issue(op(0, 0, 0, bus(WL, 0, 4, 32'h30, '0, '0), bus(WN, 0, 5, 32'h62, '0, '0)));
    idle();
    check("kept lo", 48'(rf_wr_q[0]), ex(0, 4, 32'h01234567));
    check("kept hi", 48'(rf_wr_q[1]), ex(0, 5, 32'h89abcdef));
    check("pm dropped", 48'(rf_wr_q[4].valid), 48'h0);
    check("pm nbr dropped", 48'(rf_wr_q[5].valid), 48'h0);
    check("drop flag", 48'(dropped_q), 48'h1);
    $display("done conflict");
  endtask

  // Dual-lane long and extended mix: fixed elements, nothing implicit
  task automatic t_dual_long();
    issue(op(1, 0, 0, bus(WE, 0, 0, 32'h40, 40'hc0ffee1234, '0), OFF));
    idle();
    issue(op(0, 1, 0, bus(WL, 1, 6, 32'h40, '0, '0), bus(WE, 0, 9, 32'h31, '0, '0)));
    idle();
    check("dm to primary", 48'(rf_wr_q[0]), ex(0, 6, 32'h34000000));
    check("dm nbr", 48'(rf_wr_q[1]), ex(0, 7, 32'hc0ffee12));
    check("pm to secondary", 48'(rf_wr_q[6]), {4'h3, 4'h9, 40'hfeedface0b});
    check("no implicit dm", 48'(rf_wr_q[2].valid), 48'h0);
    check("no implicit pm", 48'(rf_wr_q[4].valid), 48'h0);
    $display("done dual_long");
  endtask

  // Every width pair in both modes
  task automatic t_widths();
    logic bad;
    for (int m = 0; m < 2; m++)
      for (int a = 0; a < 4; a++)
        for (int b = 0; b < 4; b++)
        begin
          bad = (m == 1) && ((a < 2) != (b < 2));
          issue(op(0, m[0], 0, bus(ddmap_pkg::ddmap_width_t'(a[1:0]), 0, 0, 32'h30, '0, '0),
                   bus(ddmap_pkg::ddmap_width_t'(b[1:0]), 1, 8, 32'h0, '0, '0)));
          idle();
          check("refused", 48'(refused_q), 48'(bad));
          check("dm done", 48'(rf_wr_q[0].valid), 48'(!bad));
        end
    $display("done width_pairs");
  endtask

  // Odd normal dual-lane read from the array, then from the buffer
  task automatic t_odd();
    issue(op(1, 0, 0, bus(WN, 0, 0, 32'h10, 40'haaaa000177, '0), OFF));
    issue(op(1, 0, 0, bus(WN, 0, 0, 32'h11, 40'hbbbb000266, '0), OFF));
    issue(op(1, 0, 0, bus(WN, 0, 0, 32'h12, 40'hcccc000355, '0), OFF));
    idle();
    idle();
    issue(op(0, 1, 0, bus(WN, 0, 2, 32'h11, '0, '0), OFF));
    idle();
    check("odd expl", pick(0, 0, 2), ex(0, 2, 32'hbbbb0002));
    check("odd next even", pick(0, 1, 2), ex(1, 2, 32'hcccc0003));
    issue(op(1, 0, 0, bus(WN, 0, 0, 32'h11, 40'hdddd000444, '0), OFF));
    issue(op(0, 1, 0, bus(WN, 0, 3, 32'h11, '0, '0), OFF));
    idle();
    check("buffered expl", pick(0, 0, 3), ex(0, 3, 32'hdddd0004));
    check("buffered prev even", pick(0, 1, 3), ex(1, 3, 32'haaaa0001));
    issue(op(0, 1, 0, bus(WN, 1, 4, 32'h11, '0, '0), OFF));
    idle();
    check("sec odd expl", pick(0, 1, 4), ex(1, 4, 32'hdddd0004));
    check("pri next even", pick(0, 0, 4), ex(0, 4, 32'hcccc0003));
    $display("done odd_normal");
  endtask

  // Broadcast single normal, and the dual extended exception
  task automatic t_bcast();
    issue(op(0, 0, 1, bus(WN, 0, 10, 32'h12, '0, '0), OFF));
    idle();
    check("bcast primary", pick(0, 0, 10), ex(0, 10, 32'hcccc0003));
    check("bcast secondary", pick(0, 1, 10), ex(1, 10, 32'hcccc0003));
    issue(op(0, 0, 1, bus(WE, 0, 1, 32'h40, '0, '0), bus(WE, 0, 1, 32'h31, '0, '0)));
    idle();
    check("bcast ext dm", 48'(rf_wr_q[0]), {4'h2, 4'h1, 40'hc0ffee1234});
    check("bcast ext pm", 48'(rf_wr_q[6]), {4'h3, 4'h1, 40'hfeedface0b});
    $display("done broadcast");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and run control
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (1000) @(posedge clk);
    fails++;
    finish_test();
  end

  initial
  begin
    fails = 0;
    num_checks = 0;
    reset = 1'b1;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    t_reset();
    t_long();
    t_conflict();
    t_dual_long();
    t_widths();
    t_odd();
    t_bcast();
    finish_test();
  end
endmodule // tb_top
